// ### logic/dbgme_pkg.sv
// shared constants and types for the debug mode engine
package dbgme_pkg;
  localparam logic [15:0] DBGME_ROM_ENTRY = 16'h8010;
  localparam logic [3:0] DBGME_OP_GROUP = 4'h2;
  localparam logic [3:0] DBGME_OP_NOP = 4'h0;
  localparam logic [3:0] DBGME_OP_REGMAP = 4'h1;
  localparam logic [3:0] DBGME_OP_RD_MEM = 4'h2;
  localparam logic [3:0] DBGME_OP_RD_STK = 4'h3;
  localparam logic [3:0] DBGME_OP_WR_REG = 4'h4;
  localparam logic [3:0] DBGME_OP_WR_MEM = 4'h5;
  localparam logic [3:0] DBGME_OP_TRACE = 4'h6;
  localparam logic [3:0] DBGME_OP_RETURN = 4'h7;
  localparam logic [3:0] DBGME_OP_UNLOCK = 4'h8;
  localparam logic [3:0] DBGME_OP_RD_REG = 4'h9;
  // background opcode that requests debug entry; arbitrary value
  localparam logic [7:0] DBGME_BG_DEBUG_CMD = 8'h0F;
  localparam logic [2:0] DBGME_FOLLOW_FOUR = 3'h4;
  localparam logic [2:0] DBGME_FOLLOW_TWO = 3'h2;
  localparam logic [2:0] DBGME_FOLLOW_NONE = 3'h0;
  localparam logic [1:0] DBGME_ST_NON_DEBUG = 2'b00;
  localparam logic [1:0] DBGME_ST_IDLE = 2'b01;
  localparam logic [1:0] DBGME_ST_BUSY = 2'b10;
  localparam logic [1:0] DBGME_ST_VALID = 2'b11;
  localparam int DBGME_WORD_BITS = 10;
  localparam logic [3:0] DBGME_LAST_BIT = 4'h9;
  localparam logic [1:0] DBGME_IDX_ADDR_HI = 2'h1;
  localparam logic [1:0] DBGME_IDX_DATA_LO = 2'h2;
  localparam logic [1:0] DBGME_IDX_DATA_HI = 2'h3;

  typedef enum logic [2:0] {
    DBGME_BG = 3'b000,
    DBGME_ENTRY = 3'b001,
    DBGME_IDLE = 3'b010,
    DBGME_RECV = 3'b011,
    DBGME_ROM = 3'b100,
    DBGME_STEP = 3'b101,
    DBGME_RET = 3'b110
  } dbgme_state_t;

  typedef struct packed {
    logic fetch_block;
    logic push_ret;
    logic pop_ret;
    logic pc_load;
    logic [15:0] pc_value;
    logic ime_clear;
    logic ime_set;
    logic halt;
    logic rom_enable;
    logic timer_freeze;
    logic bkpt_suppress;
  } dbgme_cpu_ctl_t;
endpackage

// ### logic/dbgme_engine.sv
// debug mode engine: entry, takeover, command decode, rom hand-off
// Contract
// RULE1: enter debug on host command or breakpoint
// RULE2: entry blocks fetch, pushes, loads pc, halts
// RULE3: ignore breakpoints and debug commands in debug
// RULE4: debug freezes timers and interrupt grants
// RULE5: ready for commands shows status 01
// RULE6: trace and return in hardware, rest rom
// RULE7: decode command, await all follow-on bytes
// RULE8: host recovers by reloading test instruction
// RULE9: rom command sets code, jumps, status 10
// RULE10: shift completion clears transfer pending flag
// RULE11: clear rom task done when seen
// RULE12: undefined and 0x20 codes are no operation
// RULE13: register map sets code 0001, jumps
// RULE14: read memory takes four bytes, code 0010
// RULE15: read stack takes four bytes, code 0011
// RULE16: write register takes four bytes, code 0100
// RULE17: write memory takes four bytes, code 0101
// RULE18: trace exits, runs one instruction, re-enters
// RULE19: return resumes cpu in background mode
// RULE20: unlock code 1000, bytes into byte buffer
// RULE21: read register takes two bytes, code 1001
// RULE22: valid output tagged 11, idle when done
// RULE23: background mode reports status 00
// RULE24: no break on first instruction after return
`timescale 1ns/1ps
`default_nettype none
module dbgme_engine
  import dbgme_pkg::*;
(
  input wire logic clk_i, // system clock, 20 MHz
  input wire logic rst_b_i, // synchronous reset, active low
  input wire logic tck_i, // test port clock pin
  input wire logic tdi_i, // test port data in pin
  input wire logic shift_en_i, // test port in shift state
  input wire logic debug_ir_i, // tap_instruction_field holds debug
  output logic tdo_o, // test port data out
  input wire logic bkpt_match_i, // breakpoint matched, cpu domain
  input wire logic irq_master_enable_i, // current interrupt master enable
  input wire logic cpu_step_done_i, // one instruction retired
  input wire logic rom_buf_wr_i, // rom loads debug_byte_buffer
  input wire logic [7:0] rom_buf_data_i, // byte written by rom
  input wire logic rom_task_done_i, // rom_task_done bit of system_control_reg
  output logic rom_done_clr_o, // clear pulse for rom_task_done
  output logic transfer_pending_o, // transfer_pending_flag
  output logic [3:0] rom_command_code_o, // command code for rom
  output logic [15:0] debug_addr_holder_o, // address holder
  output logic [15:0] debug_data_holder_o, // data holder
  output logic [7:0] debug_byte_buffer_o, // byte buffer
  output logic [1:0] status_o, // status currently reported
  output dbgme_pkg::dbgme_cpu_ctl_t cpu_ctl_o // cpu takeover controls
);
  import dbgme_pkg::*;

  logic tck_s1_r, tck_s2_r, tck_s3_r;
  logic tdi_s1_r, tdi_s2_r;
  logic sen_s1_r, sen_s2_r, sen_s3_r;
  logic ir_s1_r, ir_s2_r;
  logic tck_rise, sen_rise, byte_done;
  logic [DBGME_WORD_BITS-1:0] sh_r;
  logic [3:0] bit_cnt_r;
  logic [7:0] rx_byte;
  dbgme_state_t state_r, state_nxt;
  logic [2:0] left_r, left_nxt;
  logic [1:0] idx_r;
  logic [3:0] pend_code_r;
  logic ime_saved_r, suppress_r, txc_r, done_seen_r;
  logic [1:0] status_nxt;
  dbgme_cpu_ctl_t ctl_nxt;
  logic [3:0] rx_op;
  logic rx_group;

  // pins cross into clk_i through two flops
  always_ff @(posedge clk_i)
  begin
    if (!rst_b_i)
    begin
      tck_s1_r <= 1'b0;
      tck_s2_r <= 1'b0;
      tck_s3_r <= 1'b0;
      tdi_s1_r <= 1'b0;
      tdi_s2_r <= 1'b0;
      sen_s1_r <= 1'b0;
      sen_s2_r <= 1'b0;
      sen_s3_r <= 1'b0;
      ir_s1_r <= 1'b0;
      ir_s2_r <= 1'b0;
    end
    else
    begin
      tck_s1_r <= tck_i;
      tck_s2_r <= tck_s1_r;
      tck_s3_r <= tck_s2_r;
      tdi_s1_r <= tdi_i;
      tdi_s2_r <= tdi_s1_r;
      sen_s1_r <= shift_en_i;
      sen_s2_r <= sen_s1_r;
      sen_s3_r <= sen_s2_r;
      ir_s1_r <= debug_ir_i;
      ir_s2_r <= ir_s1_r;
    end
  end

  assign tck_rise = tck_s2_r & ~tck_s3_r;
  assign sen_rise = sen_s2_r & ~sen_s3_r;
  assign byte_done = tck_rise && sen_s2_r && ir_s2_r && (bit_cnt_r == DBGME_LAST_BIT);
  // data bits are the first eight shifted in; the last two are ignored
  assign rx_byte = sh_r[DBGME_WORD_BITS-2:1];
  assign rx_op = rx_byte[3:0];
  assign rx_group = (rx_byte[7:4] == DBGME_OP_GROUP);

  // word shifter: status in the top two bits, lsb out first
  always_ff @(posedge clk_i)
  begin
    if (!rst_b_i)
    begin
      sh_r <= '0;
      bit_cnt_r <= '0;
    end
    else if (sen_rise)
    begin
      sh_r <= {status_o, debug_byte_buffer_o};
      bit_cnt_r <= '0;
    end
    else if (tck_rise && sen_s2_r)
    begin
      sh_r <= {tdi_s2_r, sh_r[DBGME_WORD_BITS-1:1]};
      bit_cnt_r <= (bit_cnt_r == DBGME_LAST_BIT) ? 4'h0 : bit_cnt_r + 4'h1;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (!rst_b_i)
      tdo_o <= 1'b0;
    else
      tdo_o <= sen_rise ? debug_byte_buffer_o[0] : sh_r[0];
  end

  always_comb
  begin
    state_nxt = state_r;
    left_nxt = left_r;
    case (state_r)
      DBGME_BG:
      begin
        // RULE1: breakpoint or host command
        if ((bkpt_match_i && !suppress_r) || (byte_done && rx_byte == DBGME_BG_DEBUG_CMD))
          state_nxt = DBGME_ENTRY;
      end
      DBGME_ENTRY:
        state_nxt = DBGME_IDLE;
      DBGME_IDLE:
      begin
        // RULE3 RULE12: entry requests and other codes are no operation
        if (byte_done && rx_group)
        begin
          case (rx_op)
            DBGME_OP_RD_MEM, DBGME_OP_RD_STK, DBGME_OP_WR_REG, DBGME_OP_WR_MEM:
            begin
              state_nxt = DBGME_RECV;
              left_nxt = DBGME_FOLLOW_FOUR;
            end
            DBGME_OP_RD_REG:
            begin
              state_nxt = DBGME_RECV;
              left_nxt = DBGME_FOLLOW_TWO;
            end
            DBGME_OP_REGMAP, DBGME_OP_UNLOCK:
            begin
              state_nxt = DBGME_ROM;
              left_nxt = DBGME_FOLLOW_NONE;
            end
            // RULE6: trace and return stay in hardware
            DBGME_OP_TRACE: state_nxt = DBGME_STEP;
            DBGME_OP_RETURN: state_nxt = DBGME_RET;
            default: state_nxt = DBGME_IDLE;
          endcase
        end
      end
      DBGME_RECV:
      begin
        // RULE8: dropping the debug instruction abandons the command
        if (!ir_s2_r)
          state_nxt = DBGME_IDLE;
        // RULE7: no timeout, wait for the last byte
        else if (byte_done)
        begin
          left_nxt = left_r - 3'h1;
          if (left_r == 3'h1)
            state_nxt = DBGME_ROM;
        end
      end
      DBGME_ROM:
      begin
        // RULE22: idle again once rom reports done
        if (rom_task_done_i && !done_seen_r)
          state_nxt = DBGME_IDLE;
      end
      DBGME_STEP:
      begin
        // RULE18: one instruction, then full re-entry
        if (cpu_step_done_i)
          state_nxt = DBGME_ENTRY;
      end
      DBGME_RET:
        state_nxt = DBGME_BG;
      default:
        state_nxt = DBGME_BG;
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (!rst_b_i)
    begin
      state_r <= DBGME_BG;
      left_r <= DBGME_FOLLOW_NONE;
    end
    else
    begin
      state_r <= state_nxt;
      left_r <= left_nxt;
    end
  end

  // follow-on bytes, lsb first, into address then data holder
  always_ff @(posedge clk_i)
  begin
    if (!rst_b_i)
    begin
      idx_r <= '0;
      pend_code_r <= DBGME_OP_NOP;
      debug_addr_holder_o <= '0;
      debug_data_holder_o <= '0;
    end
    else if (state_r == DBGME_IDLE && byte_done && rx_group)
    begin
      idx_r <= '0;
      pend_code_r <= rx_op;
    end
    else if (state_r == DBGME_RECV && byte_done && ir_s2_r)
    begin
      // RULE14: address then count; RULE15 RULE16 RULE17 RULE21 share path
      case (idx_r)
        2'h0: debug_addr_holder_o[7:0] <= rx_byte;
        DBGME_IDX_ADDR_HI: debug_addr_holder_o[15:8] <= rx_byte;
        DBGME_IDX_DATA_LO: debug_data_holder_o[7:0] <= rx_byte;
        DBGME_IDX_DATA_HI: debug_data_holder_o[15:8] <= rx_byte;
        default: debug_data_holder_o <= debug_data_holder_o;
      endcase
      idx_r <= idx_r + 2'h1;
    end
  end

  // RULE9: code written when the rom jump happens
  // RULE13: register map jumps with no follow-on
  always_ff @(posedge clk_i)
  begin
    if (!rst_b_i)
      rom_command_code_o <= DBGME_OP_NOP;
    else if (state_nxt == DBGME_ROM && state_r != DBGME_ROM)
      rom_command_code_o <= (state_r == DBGME_IDLE) ? rx_op : pend_code_r;
  end

  // RULE20: password bytes land in the byte buffer as they come
  always_ff @(posedge clk_i)
  begin
    if (!rst_b_i)
      debug_byte_buffer_o <= '0;
    else if (state_r == DBGME_ROM && byte_done && rom_command_code_o == DBGME_OP_UNLOCK)
      debug_byte_buffer_o <= rx_byte;
    else if (rom_buf_wr_i)
      debug_byte_buffer_o <= rom_buf_data_i;
  end

  // RULE10: shift completion clears; a same-cycle rom load wins
  always_ff @(posedge clk_i)
  begin
    if (!rst_b_i)
      txc_r <= 1'b0;
    else if (rom_buf_wr_i)
      txc_r <= 1'b1;
    else if (byte_done && state_r == DBGME_ROM)
      txc_r <= 1'b0;
  end
  assign transfer_pending_o = txc_r;

  // RULE11: one clear pulse per done indication
  always_ff @(posedge clk_i)
  begin
    if (!rst_b_i)
    begin
      done_seen_r <= 1'b0;
      rom_done_clr_o <= 1'b0;
    end
    else
    begin
      done_seen_r <= rom_task_done_i;
      rom_done_clr_o <= rom_task_done_i && !done_seen_r && state_r == DBGME_ROM;
    end
  end

  // interrupt enable captured at first entry only; trace keeps it
  always_ff @(posedge clk_i)
  begin
    if (!rst_b_i)
      ime_saved_r <= 1'b0;
    else if (state_r == DBGME_BG && state_nxt == DBGME_ENTRY)
      ime_saved_r <= irq_master_enable_i;
  end

  // RULE24: hold off breakpoints until first instruction retires
  always_ff @(posedge clk_i)
  begin
    if (!rst_b_i)
      suppress_r <= 1'b0;
    else if (state_r == DBGME_RET)
      suppress_r <= 1'b1;
    else if (cpu_step_done_i)
      suppress_r <= 1'b0;
  end

  always_comb
  begin
    // RULE23: non-debug in background
    status_nxt = DBGME_ST_NON_DEBUG;
    case (state_nxt)
      // RULE5: ready for commands
      DBGME_IDLE, DBGME_RECV: status_nxt = DBGME_ST_IDLE;
      // RULE22: valid byte waiting is tagged 11
      DBGME_ROM: status_nxt = txc_r ? DBGME_ST_VALID : DBGME_ST_BUSY;
      DBGME_ENTRY, DBGME_STEP, DBGME_RET: status_nxt = DBGME_ST_BUSY;
      default: status_nxt = DBGME_ST_NON_DEBUG;
    endcase
  end

  always_comb
  begin
    ctl_nxt = '0;
    ctl_nxt.pc_value = DBGME_ROM_ENTRY;
    ctl_nxt.bkpt_suppress = suppress_r || (state_r == DBGME_RET);
    // RULE2: entry takeover sequence
    if (state_nxt == DBGME_ENTRY)
    begin
      ctl_nxt.fetch_block = 1'b1;
      ctl_nxt.push_ret = 1'b1;
      ctl_nxt.pc_load = 1'b1;
      ctl_nxt.ime_clear = (state_r == DBGME_BG) ? irq_master_enable_i : ime_saved_r;
      ctl_nxt.halt = 1'b1;
    end
    if (state_nxt == DBGME_IDLE || state_nxt == DBGME_RECV)
    begin
      ctl_nxt.fetch_block = 1'b1;
      ctl_nxt.halt = 1'b1;
    end
    // RULE9: jump into rom, enabling it
    if (state_nxt == DBGME_ROM)
    begin
      ctl_nxt.rom_enable = 1'b1;
      ctl_nxt.pc_load = (state_r != DBGME_ROM);
    end
    // RULE19: pop and restore the enable on leaving
    if ((state_nxt == DBGME_STEP || state_nxt == DBGME_RET) && state_r == DBGME_IDLE)
    begin
      ctl_nxt.pop_ret = 1'b1;
      ctl_nxt.ime_set = ime_saved_r;
    end
    // RULE4: timers stopped in every debug state except the one-cycle return state
    ctl_nxt.timer_freeze = (state_nxt != DBGME_BG) && (state_nxt != DBGME_RET);
  end

  always_ff @(posedge clk_i)
  begin
    if (!rst_b_i)
    begin
      cpu_ctl_o <= '0;
      status_o <= DBGME_ST_NON_DEBUG;
    end
    else
    begin
      cpu_ctl_o <= ctl_nxt;
      status_o <= status_nxt;
    end
  end

  a_bkpt_enters: assert property (@(posedge clk_i) disable iff (!rst_b_i) // RULE1
    state_r == DBGME_BG && bkpt_match_i && !suppress_r |=> cpu_ctl_o.halt && cpu_ctl_o.push_ret)
    else $error("breakpoint did not enter debug");
  a_entry_pc: assert property (@(posedge clk_i) disable iff (!rst_b_i) // RULE2
    $rose(cpu_ctl_o.push_ret) |-> cpu_ctl_o.pc_load && cpu_ctl_o.pc_value == DBGME_ROM_ENTRY && cpu_ctl_o.fetch_block)
    else $error("entry did not load rom address");
  a_no_reentry: assert property (@(posedge clk_i) disable iff (!rst_b_i) // RULE3
    state_r == DBGME_IDLE && bkpt_match_i && !byte_done |=> state_r == DBGME_IDLE)
    else $error("breakpoint disturbed debug idle");
  a_timer_freeze: assert property (@(posedge clk_i) disable iff (!rst_b_i) // RULE4
    state_r == DBGME_IDLE |-> cpu_ctl_o.timer_freeze && cpu_ctl_o.halt)
    else $error("timers running in debug idle");
  a_idle_status: assert property (@(posedge clk_i) disable iff (!rst_b_i) // RULE5
    $rose(state_r == DBGME_IDLE) |-> status_o == DBGME_ST_IDLE)
    else $error("idle status wrong");
  a_wait_bytes: assert property (@(posedge clk_i) disable iff (!rst_b_i) // RULE7
    state_r == DBGME_RECV && left_r > 3'h1 |=> state_r != DBGME_ROM)
    else $error("rom started before all bytes");
  a_rom_busy: assert property (@(posedge clk_i) disable iff (!rst_b_i) // RULE9
    state_r != DBGME_ROM && state_nxt == DBGME_ROM |=> cpu_ctl_o.rom_enable && cpu_ctl_o.pc_load && status_o[1])
    else $error("rom jump incomplete");
  a_txc_clear: assert property (@(posedge clk_i) disable iff (!rst_b_i) // RULE10
    state_r == DBGME_ROM && byte_done && !rom_buf_wr_i |=> !transfer_pending_o)
    else $error("pending flag not cleared");
  a_done_clear: assert property (@(posedge clk_i) disable iff (!rst_b_i) // RULE11
    state_r == DBGME_ROM && $rose(rom_task_done_i) |=> rom_done_clr_o ##1 !rom_done_clr_o)
    else $error("rom done not cleared");
  a_bg_status: assert property (@(posedge clk_i) disable iff (!rst_b_i) // RULE23
    state_r == DBGME_BG && $past(state_r) == DBGME_BG |-> status_o == DBGME_ST_NON_DEBUG)
    else $error("background status wrong");
  a_ret_suppress: assert property (@(posedge clk_i) disable iff (!rst_b_i) // RULE24
    state_r == DBGME_RET |=> suppress_r && state_r == DBGME_BG)
    else $error("return did not suppress breakpoint");
endmodule // dbgme_engine
`default_nettype wire

// ### bench/dbgme_host.sv
// host debugger model on the serial test port
`timescale 1ns/1ps
`default_nettype none
module dbgme_host
(
  input wire logic clk_i, // system clock
  input wire logic tdo_i, // serial data from device
  output logic tck_o, // test clock, still between frames
  output logic tdi_o, // test data to device
  output logic shift_en_o, // shift state
  output logic debug_ir_o // debug instruction loaded
);
  initial
  begin
    tck_o = 1'b0;
    tdi_o = 1'b0;
    shift_en_o = 1'b0;
    debug_ir_o = 1'b1;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask

  task automatic xfer(input logic [7:0] b, output logic [9:0] w);
    shift_en_o <= 1'b1;
    tick(7);
    for (int i = 0; i < 10; i++)
    begin
      w[i] = tdo_i;
      tdi_o <= (i < 8) ? b[i] : ~tdi_o;
      tick(2);
      tck_o <= 1'b1;
      tick(4);
      tck_o <= 1'b0;
      tick(2);
    end
    // released data line must not hold its last bit
    tdi_o <= ~tdi_o;
    shift_en_o <= 1'b0;
    tick(4);
  endtask

  // drop and reload the debug instruction
  task automatic recover;
    debug_ir_o <= 1'b0;
    tick(6);
    debug_ir_o <= 1'b1;
    tick(6);
  endtask
endmodule // dbgme_host
`default_nettype wire

// ### bench/dbgme_engine_tb_top.sv
// self-checking bench for the debug mode engine
`timescale 1ns/1ps
`default_nettype none
module dbgme_engine_tb_top;
  import dbgme_pkg::*;
  logic clk_i;
  logic rst_b_i;
  logic tck, tdi, sh_en, dbg_ir, tdo;
  logic bkpt, ime, step, bwr, rdone, dclr, pend;
  logic [7:0] bdata;
  logic [7:0] buff;
  logic [3:0] code;
  logic [15:0] addr;
  logic [15:0] data;
  logic [1:0] st;
  dbgme_cpu_ctl_t ctl;
  int err_count = 0;
  int check_count = 0;
  int n_push = 0;
  int n_pop = 0;
  int n_pcl = 0;
  int n_clr = 0;
  int n_imc = 0;
  int n_ims = 0;

  dbgme_engine i_dbgme_engine (.clk_i(clk_i), .rst_b_i(rst_b_i), .tck_i(tck), .tdi_i(tdi),
    .shift_en_i(sh_en), .debug_ir_i(dbg_ir), .tdo_o(tdo), .bkpt_match_i(bkpt),
    .irq_master_enable_i(ime), .cpu_step_done_i(step), .rom_buf_wr_i(bwr),
    .rom_buf_data_i(bdata), .rom_task_done_i(rdone), .rom_done_clr_o(dclr),
    .transfer_pending_o(pend), .rom_command_code_o(code), .debug_addr_holder_o(addr),
    .debug_data_holder_o(data), .debug_byte_buffer_o(buff), .status_o(st), .cpu_ctl_o(ctl));

  dbgme_host i_dbgme_host (.clk_i(clk_i), .tdo_i(tdo), .tck_o(tck), .tdi_o(tdi),
    .shift_en_o(sh_en), .debug_ir_o(dbg_ir));

  initial
  begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end

  // counting pulses exposes an output stuck high
  always @(posedge clk_i)
  begin
    n_push <= n_push + int'(ctl.push_ret === 1'b1);
    n_pop <= n_pop + int'(ctl.pop_ret === 1'b1);
    n_pcl <= n_pcl + int'(ctl.pc_load === 1'b1);
    n_clr <= n_clr + int'(dclr === 1'b1);
    n_imc <= n_imc + int'(ctl.ime_clear === 1'b1);
    n_ims <= n_ims + int'(ctl.ime_set === 1'b1);
  end

  task automatic end_of_test;
    $display("errors %0d checks %0d", err_count, check_count);
    if (err_count == 0 && check_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      err_count++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic fail(input string nm);
    err_count++;
    $display("mismatch %s expected done seen timeout", nm);
    end_of_test;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask

  task automatic wait_st(input logic [1:0] s);
    int k;
    for (k = 0; k < 400 && st !== s; k++)
      tick(1);
    if (st !== s)
      fail("status wait");
  endtask

  task automatic send(input logic [7:0] b);
    logic [9:0] w;
    i_dbgme_host.xfer(b, w);
    tick(3);
  endtask

  task automatic pulse_bkpt;
    bkpt <= 1'b1;
    tick(1);
    bkpt <= 1'b0;
    tick(1);
  endtask

  task automatic pulse_step;
    step <= 1'b1;
    tick(1);
    step <= 1'b0;
    tick(1);
  endtask

  task automatic rom_done;
    int c;
    int k;
    c = n_clr;
    rdone <= 1'b1;
    for (k = 0; k < 100 && n_clr == c; k++)
      tick(1);
    if (k == 100)
      fail("rom done clear");
    rdone <= 1'b0;
    tick(3);
    chk("done_clr", n_clr - c, 1);
    wait_st(DBGME_ST_IDLE);
  endtask

  task automatic t_enter;
    int p;
    int q;
    dbgme_cpu_ctl_t e;
    p = n_push;
    q = n_imc;
    // the rom entry address is always offered, every strobe idle
    e = '0;
    e.pc_value = DBGME_ROM_ENTRY;
    chk("bg_status", st, DBGME_ST_NON_DEBUG);
    chk("rst_ctl", ctl, e);
    send(DBGME_BG_DEBUG_CMD);
    wait_st(DBGME_ST_IDLE);
    chk("push", n_push - p, 1);
    chk("ime_clr", n_imc - q, 1);
    chk("pc", ctl.pc_value, DBGME_ROM_ENTRY);
    chk("halt", {ctl.halt, ctl.fetch_block}, 2'b11);
    chk("freeze", ctl.timer_freeze, 1'b1);
  endtask

  // entry requests and undefined codes while already in debug
  task automatic t_ignore;
    int p;
    p = n_push;
    send(DBGME_BG_DEBUG_CMD);
    pulse_bkpt();
    send(8'h20);
    send(8'h2A);
    send(8'h33);
    tick(4);
    chk("no_push", n_push - p, 0);
    chk("nop_code", code, 4'h0);
    chk("nop_st", st, DBGME_ST_IDLE);
  endtask

  task automatic t_rom;
    logic [7:0] cmd [5];
    logic [7:0] b [4];
    int p;
    cmd = '{8'h22, 8'h23, 8'h24, 8'h25, 8'h29};
    for (int i = 0; i < 5; i++)
    begin
      p = n_pcl;
      send(cmd[i]);
      for (int k = 0; k < 4; k++)
        b[k] = 8'(16 * i + 3 * k + 1);
      for (int k = 0; k < ((i == 4) ? 2 : 4); k++)
      begin
        chk("wait_st", st, DBGME_ST_IDLE);
        send(b[k]);
      end
      chk("code", code, cmd[i][3:0]);
      chk("addr", addr, {b[1], b[0]});
      if (i < 4)
        chk("data", data, {b[3], b[2]});
      chk("busy", st, DBGME_ST_BUSY);
      chk("rom_en", ctl.rom_enable, 1'b1);
      chk("jump", n_pcl - p, 1);
      rom_done();
    end
  endtask

  task automatic t_regmap;
    logic [9:0] w;
    send(8'h21);
    chk("map_code", code, 4'h1);
    chk("map_st", st, DBGME_ST_BUSY);
    bdata <= 8'h5A;
    bwr <= 1'b1;
    tick(1);
    bwr <= 1'b0;
    tick(4);
    chk("pend", pend, 1'b1);
    chk("valid", st, DBGME_ST_VALID);
    i_dbgme_host.xfer(8'h00, w);
    tick(3);
    chk("out_word", w, {DBGME_ST_VALID, 8'h5A});
    chk("pend_clr", pend, 1'b0);
    rom_done();
  endtask

  task automatic t_unlock;
    send(8'h28);
    chk("unl_code", code, 4'h8);
    for (int k = 0; k < 32; k++)
    begin
      send(8'(8'hC3 ^ k));
      chk("unl_byte", buff, 8'(8'hC3 ^ k));
    end
    rom_done();
  endtask

  // out-of-order host, then reload of the debug instruction
  task automatic t_recover;
    send(8'h22);
    send(8'h77);
    send(8'h66);
    i_dbgme_host.recover();
    send(8'h29);
    send(8'h34);
    send(8'h12);
    chk("rcv_code", code, 4'h9);
    chk("rcv_addr", addr, 16'h1234);
    rom_done();
  endtask

  task automatic t_trace;
    int p;
    int q;
    int r;
    p = n_push;
    q = n_pop;
    r = n_ims;
    send(8'h26);
    chk("tr_pop", n_pop - q, 1);
    chk("tr_ime", n_ims - r, 1);
    chk("tr_run", ctl.halt, 1'b0);
    pulse_step();
    wait_st(DBGME_ST_IDLE);
    chk("tr_push", n_push - p, 1);
    chk("tr_halt", ctl.halt, 1'b1);
  endtask

  task automatic t_return;
    int p;
    send(8'h27);
    wait_st(DBGME_ST_NON_DEBUG);
    chk("ret_run", {ctl.halt, ctl.timer_freeze}, 2'b00);
    chk("ret_sup", ctl.bkpt_suppress, 1'b1);
    p = n_push;
    pulse_bkpt();
    tick(10);
    chk("sup_push", n_push - p, 0);
    chk("sup_st", st, DBGME_ST_NON_DEBUG);
    pulse_step();
    pulse_bkpt();
    wait_st(DBGME_ST_IDLE);
    chk("bk_push", n_push - p, 1);
  endtask

  initial
  begin
    rst_b_i = 1'b0;
    bkpt = 1'b0;
    ime = 1'b1;
    step = 1'b0;
    bwr = 1'b0;
    bdata = 8'h00;
    rdone = 1'b0;
    tick(2);
    rst_b_i <= 1'b1;
    tick(5);
    t_enter();
    t_ignore();
    t_rom();
    t_regmap();
    t_unlock();
    t_recover();
    t_trace();
    t_return();
    end_of_test();
  end
endmodule // dbgme_engine_tb_top
`default_nettype wire
